// ### hdl/gpd_predriver_if.v
// Digital host interface of a three-phase gate pre-driver.
//
// What this block does
// - Every gate output stays off unless both drive enables are high.
// - A low high-side command of a phase turns that phase's high-side driver on, a high one off.
// - A high low-side command of a phase turns that phase's low-side driver on, a low one off.
// - Each phase status output is low while its switch node is below half the load supply.
// - Chip select low frames one serial command and the serial port acts only inside it.
// - Serial input is sent MSB first and sampled on each falling serial clock edge.
// - The serial output is released until chip select goes low and driven only after that.
// - A programmable deadtime of 50 ns to 12 us separates one side turning off and the other on.
// - High and low side of a phase are never on together, whatever the commands ask.
// - Reset acts asynchronously to the serial clock and an interrupt output is provided.
// - Overcurrent, desaturation and phase faults are caught and readable over the serial port.
`timescale 1ns/1ps
`default_nettype none
`include "gpd_map.vh"

module gpd_predriver_if #(
   parameter PHASES = 3,
   parameter DT_W = 8
) (
   // Clock, reset and freeze.
   input wire clk,
   input wire rstn,
   input wire ce,
   // Drive enables.
   input wire drive_enable_first,
   input wire drive_enable_second,
   // Direct phase commands.
   input wire phase_a_high_cmd_n,
   input wire phase_b_high_cmd_n,
   input wire phase_c_high_cmd_n,
   input wire phase_a_low_cmd,
   input wire phase_b_low_cmd,
   input wire phase_c_low_cmd,
   // Switch node comparators, high at or above half the load supply.
   input wire phase_a_switch_node,
   input wire phase_b_switch_node,
   input wire phase_c_switch_node,
   // Fault detectors.
   input wire overcurrent_detect,
   input wire desat_detect,
   input wire phase_fault_detect,
   // Serial port.
   input wire spi_cs_n,
   input wire spi_sclk,
   input wire spi_si,
   output wire spi_so_out,
   output wire spi_so_oe,
   // Gate commands.
   output wire phase_a_high_gate,
   output wire phase_b_high_gate,
   output wire phase_c_high_gate,
   output wire phase_a_low_gate,
   output wire phase_b_low_gate,
   output wire phase_c_low_gate,
   // Status to the controller.
   output wire phase_a_level_status,
   output wire phase_b_level_status,
   output wire phase_c_level_status,
   output wire interrupt_out
);

   // Positions in the synchronised pin vector.
   localparam PIN_W = 17;
   localparam P_EN1 = 0;
   localparam P_EN2 = 1;
   localparam P_HI = 2;
   localparam P_LO = 5;
   localparam P_NODE = 8;
   localparam P_CS = 11;
   localparam P_SCLK = 12;
   localparam P_SI = 13;
   localparam P_FLT = 14;
   // Inactive levels: chip select, serial clock and high-side commands idle high.
   localparam [PIN_W-1:0] PIN_IDLE = 17'h0181C;
   // The integer cycle counts are cut to the deadtime width on purpose.
   localparam integer DT_MIN_I = `GPD_DT_MIN_CYC;
   localparam integer DT_MAX_I = `GPD_DT_MAX_CYC;
   localparam integer DT_RESET_I = `GPD_DT_RESET_CYC;
   localparam [DT_W-1:0] DT_MIN = DT_MIN_I[DT_W-1:0];
   localparam [DT_W-1:0] DT_MAX = DT_MAX_I[DT_W-1:0];
   localparam [DT_W-1:0] DT_RESET = DT_RESET_I[DT_W-1:0];

   // Reset release.
   reg rst_s1_reg;
   reg rst_s2_reg;
   wire rst_n;

   // Pin synchroniser and agreement filter.
   wire [PIN_W-1:0] pin_raw;
   reg [PIN_W-1:0] pin_s1_reg;
   reg [PIN_W-1:0] pin_s2_reg;
   reg [PIN_W-1:0] pin_s3_reg;
   reg [PIN_W-1:0] pin_filt_reg;
   wire [PIN_W-1:0] pin_filt_next;
   reg cs_prev_reg;
   reg sclk_prev_reg;

   // Serial engine.
   reg [4:0] bit_cnt_reg;
   reg [15:0] rx_shift_reg;
   reg [15:0] tx_shift_reg;
   reg so_out_reg;
   reg so_oe_reg;
   reg frame_err_reg;

   // Configuration and status.
   reg [DT_W-1:0] dt_reg;
   reg [2:0] fault_reg;
   reg [2:0] fault_clr;
   wire [2:0] fault_next;
   reg int_reg;
   reg [PHASES-1:0] level_reg;
   reg [DT_W-1:0] dt_req;

   // Decoded serial events.
   wire cs_active;
   wire cs_fall;
   wire cs_rise;
   wire sclk_fall;
   wire sclk_rise;
   wire frame_ok;
   wire [2:0] rx_cmd;
   wire [15:0] status_word;

   // Phase legs.
   wire drive_enable;
   wire [PHASES-1:0] high_req;
   wire [PHASES-1:0] low_req;
   wire [PHASES-1:0] high_gate;
   wire [PHASES-1:0] low_gate;

   // The async reset asserts at once and releases through two flops.
   always @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rst_s1_reg <= 1'b0;
         rst_s2_reg <= 1'b0;
      end else begin
         rst_s1_reg <= 1'b1;
         rst_s2_reg <= rst_s1_reg;
      end
   end
   assign rst_n = rst_s2_reg;

   assign pin_raw = {phase_fault_detect, desat_detect, overcurrent_detect,
                     spi_si, spi_sclk, spi_cs_n,
                     phase_c_switch_node, phase_b_switch_node, phase_a_switch_node,
                     phase_c_low_cmd, phase_b_low_cmd, phase_a_low_cmd,
                     phase_c_high_cmd_n, phase_b_high_cmd_n, phase_a_high_cmd_n,
                     drive_enable_second, drive_enable_first};

   // A bit changes only once the second and third stages agree.
   assign pin_filt_next = (pin_s2_reg & pin_s3_reg) |
                          (pin_filt_reg & (pin_s2_reg | pin_s3_reg));

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pin_s1_reg <= PIN_IDLE;
         pin_s2_reg <= PIN_IDLE;
         pin_s3_reg <= PIN_IDLE;
         pin_filt_reg <= PIN_IDLE;
         cs_prev_reg <= 1'b1;
         sclk_prev_reg <= 1'b1;
      end else if (ce) begin
         pin_s1_reg <= pin_raw;
         pin_s2_reg <= pin_s1_reg;
         pin_s3_reg <= pin_s2_reg;
         pin_filt_reg <= pin_filt_next;
         cs_prev_reg <= pin_filt_reg[P_CS];
         sclk_prev_reg <= pin_filt_reg[P_SCLK];
      end
   end

   // Edges are found by sampling, so the serial clock must stay well below the core clock.
   assign cs_active = ~pin_filt_reg[P_CS];
   assign cs_fall = cs_prev_reg & ~pin_filt_reg[P_CS];
   assign cs_rise = ~cs_prev_reg & pin_filt_reg[P_CS];
   assign sclk_fall = sclk_prev_reg & ~pin_filt_reg[P_SCLK] & cs_active;
   assign sclk_rise = ~sclk_prev_reg & pin_filt_reg[P_SCLK] & cs_active;

   assign frame_ok = (bit_cnt_reg == `GPD_FRAME_BITS);
   assign rx_cmd = rx_shift_reg[`GPD_CMD_MSB:`GPD_CMD_LSB];
   assign status_word = {int_reg, fault_reg, level_reg, dt_reg, frame_err_reg};

   // Serial engine: sample on falling edges, shift the reply on rising edges.
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         bit_cnt_reg <= 5'h00;
         rx_shift_reg <= 16'h0000;
         tx_shift_reg <= 16'h0000;
         so_out_reg <= 1'b0;
         so_oe_reg <= 1'b0;
         frame_err_reg <= 1'b0;
      end else if (ce) begin
         if (cs_fall) begin
            bit_cnt_reg <= 5'h00;
            tx_shift_reg <= status_word;
            so_out_reg <= status_word[15];
            so_oe_reg <= 1'b1;
         end else if (cs_rise) begin
            so_oe_reg <= 1'b0;
            frame_err_reg <= ~frame_ok;
         end else if (sclk_fall) begin
            rx_shift_reg <= {rx_shift_reg[14:0], pin_filt_reg[P_SI]};
            if (bit_cnt_reg != 5'h1F) begin
               bit_cnt_reg <= bit_cnt_reg + 5'h01;
            end
         end else if (sclk_rise && bit_cnt_reg != 5'h00) begin
            tx_shift_reg <= {tx_shift_reg[14:0], 1'b0};
            so_out_reg <= tx_shift_reg[14];
         end
      end
   end

   // Requested deadtime, held inside the supported range.
   always @* begin
      dt_req = rx_shift_reg[`GPD_DATA_MSB:`GPD_DATA_LSB];
      if (dt_req < DT_MIN) begin
         dt_req = DT_MIN;
      end else if (dt_req > DT_MAX) begin
         dt_req = DT_MAX;
      end
   end

   // Commands take effect only when a whole frame closes.
   always @* begin
      fault_clr = 3'h0;
      if (cs_rise && frame_ok && rx_cmd == `GPD_CMD_CLEAR_FAULTS) begin
         fault_clr = rx_shift_reg[2:0];
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         dt_reg <= DT_RESET;
      end else if (ce) begin
         if (cs_rise && frame_ok && rx_cmd == `GPD_CMD_SET_DEADTIME) begin
            dt_reg <= dt_req;
         end
      end
   end

   // A fault present in the clearing cycle survives the clear.
   assign fault_next = (fault_reg & ~fault_clr) | pin_filt_reg[P_FLT+2:P_FLT];

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fault_reg <= 3'h0;
         int_reg <= 1'b0;
         level_reg <= {PHASES{1'b0}};
      end else if (ce) begin
         fault_reg <= fault_next;
         int_reg <= |fault_next;
         level_reg <= pin_filt_reg[P_NODE+PHASES-1:P_NODE];
      end
   end

   assign drive_enable = pin_filt_reg[P_EN1] & pin_filt_reg[P_EN2];
   assign high_req = ~pin_filt_reg[P_HI+PHASES-1:P_HI];
   assign low_req = pin_filt_reg[P_LO+PHASES-1:P_LO];

   genvar ph;
   generate
      for (ph = 0; ph < PHASES; ph = ph + 1) begin : g_leg
         gpd_deadtime #(
            .CNT_W(DT_W)
         ) u_leg (
            .clk(clk),
            .rst_n(rst_n),
            .ce(ce),
            .enable(drive_enable),
            .high_req(high_req[ph]),
            .low_req(low_req[ph]),
            .dt_cycles(dt_reg),
            .high_gate(high_gate[ph]),
            .low_gate(low_gate[ph])
         );
      end
   endgenerate

   assign phase_a_high_gate = high_gate[0];
   assign phase_b_high_gate = high_gate[1];
   assign phase_c_high_gate = high_gate[2];
   assign phase_a_low_gate = low_gate[0];
   assign phase_b_low_gate = low_gate[1];
   assign phase_c_low_gate = low_gate[2];
   assign phase_a_level_status = level_reg[0];
   assign phase_b_level_status = level_reg[1];
   assign phase_c_level_status = level_reg[2];
   assign interrupt_out = int_reg;
   assign spi_so_out = so_out_reg;
   assign spi_so_oe = so_oe_reg;

endmodule // gpd_predriver_if

`default_nettype wire

// ### hdl/gpd_map.vh
// Constants of the gate pre-driver logic interface: frame layout, commands, timing.
`ifndef GPD_MAP_VH
`define GPD_MAP_VH

// Serial frame layout, most significant bit first.
`define GPD_FRAME_BITS 5'h10
`define GPD_CMD_MSB 15
`define GPD_CMD_LSB 13
`define GPD_DATA_MSB 7
`define GPD_DATA_LSB 0

// Command codes carried in the top three bits of a frame.
`define GPD_CMD_NOP 3'h0
`define GPD_CMD_SET_DEADTIME 3'h1
`define GPD_CMD_CLEAR_FAULTS 3'h2

// Fault bit positions in the fault vector and in a clear command.
`define GPD_FLT_OVERCURRENT 0
`define GPD_FLT_DESAT 1
`define GPD_FLT_PHASE 2

// Timing: clock rate and deadtime range.
`define GPD_CLK_MHZ 20
`define GPD_DT_MIN_NS 50
`define GPD_DT_MAX_NS 12000
`define GPD_DT_RESET_NS 1000
`define GPD_DT_MIN_CYC ((`GPD_DT_MIN_NS * `GPD_CLK_MHZ + 999) / 1000)
`define GPD_DT_MAX_CYC ((`GPD_DT_MAX_NS * `GPD_CLK_MHZ) / 1000)
`define GPD_DT_RESET_CYC ((`GPD_DT_RESET_NS * `GPD_CLK_MHZ) / 1000)

`endif

// ### hdl/gpd_deadtime.v
// One phase leg: enable gating, shoot-through interlock and deadtime insertion.
`timescale 1ns/1ps
`default_nettype none

module gpd_deadtime #(
   parameter CNT_W = 8
) (
   // Clock, reset and freeze.
   input wire clk,
   input wire rst_n,
   input wire ce,
   // Requests for this leg.
   input wire enable,
   input wire high_req,
   input wire low_req,
   input wire [CNT_W-1:0] dt_cycles,
   // Gate commands.
   output wire high_gate,
   output wire low_gate
);

   reg high_on_reg;
   reg low_on_reg;
   reg [CNT_W-1:0] gap_cnt_reg;
   wire want_high;
   wire want_low;
   localparam [CNT_W-1:0] ONE = {{(CNT_W-1){1'b0}}, 1'b1};

   // A conflicting request turns both sides off rather than choosing one.
   assign want_high = enable & high_req & ~low_req;
   assign want_low = enable & low_req & ~high_req;

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         high_on_reg <= 1'b0;
         low_on_reg <= 1'b0;
         gap_cnt_reg <= {CNT_W{1'b0}};
      end else if (ce) begin
         if (high_on_reg && !want_high) begin
            high_on_reg <= 1'b0;
            gap_cnt_reg <= dt_cycles - ONE;
         end else if (low_on_reg && !want_low) begin
            low_on_reg <= 1'b0;
            gap_cnt_reg <= dt_cycles - ONE;
         end else if (gap_cnt_reg != {CNT_W{1'b0}}) begin
            gap_cnt_reg <= gap_cnt_reg - ONE;
         end else if (want_high && !low_on_reg) begin
            high_on_reg <= 1'b1;
         end else if (want_low && !high_on_reg) begin
            low_on_reg <= 1'b1;
         end
      end
   end

   assign high_gate = high_on_reg;
   assign low_gate = low_on_reg;

endmodule // gpd_deadtime

`default_nettype wire

// ### dv/gpd_checker.sv
// Assertion checker for the gate pre-driver interface, with its bind.
`timescale 1ns/1ps
`default_nettype none
module gpd_checker (
   // Clock, reset, enables and phase A inputs.
   input wire clk, rstn, drive_enable_first, drive_enable_second,
   input wire phase_a_high_cmd_n, phase_a_low_cmd, phase_a_switch_node,
   // Overcurrent and chip select inputs, serial, interrupt and phase A outputs.
   input wire overcurrent_detect, spi_cs_n, spi_so_oe, interrupt_out,
   input wire phase_a_level_status, phase_a_high_gate, phase_a_low_gate
);
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rstn);
   wire en_both = drive_enable_first && drive_enable_second;
   wire hg = phase_a_high_gate;
   wire lg = phase_a_low_gate;
   AST_EN_AND: assert property ((!en_both)[*8] |-> !hg && !lg)
      else $error("gate on without both enables");
   AST_HI_OFF: assert property (phase_a_high_cmd_n[*8] |-> !hg)
      else $error("high gate on while not asked");
   AST_LO_OFF: assert property ((!phase_a_low_cmd)[*8] |-> !lg)
      else $error("low gate on while not asked");
   AST_LEVEL: assert property ($stable(phase_a_switch_node)[*8]
      |-> phase_a_level_status == phase_a_switch_node)
      else $error("level status differs from its node");
   AST_SO_ON: assert property ((!spi_cs_n)[*8] |-> spi_so_oe)
      else $error("serial output not driven in frame");
   AST_SO_OFF: assert property (spi_cs_n[*8] |-> !spi_so_oe)
      else $error("serial output driven outside frame");
   AST_DT_HL: assert property ($fell(hg) |-> !lg)
      else $error("low gate on right after high gate off");
   AST_DT_LH: assert property ($fell(lg) |-> !hg)
      else $error("high gate on right after low gate off");
   AST_SHOOT: assert property (!(hg && lg))
      else $error("both gates of a phase on");
   AST_FLT_SET: assert property (overcurrent_detect[*8] |-> interrupt_out)
      else $error("fault did not raise interrupt");
   AST_INT_HOLD: assert property (spi_cs_n[*8] ##0 interrupt_out |=> interrupt_out)
      else $error("interrupt dropped without a clear");
   CV_GAP: cover property ($fell(hg) ##[1:300] $rose(lg));
   CV_FRAME: cover property ($rose(spi_so_oe) ##[1:300] $fell(spi_so_oe));
   CV_CLEAR: cover property ($fell(interrupt_out));
endmodule // gpd_checker
bind gpd_predriver_if gpd_checker i_chk (.clk(clk), .rstn(rstn),
   .drive_enable_first(drive_enable_first), .drive_enable_second(drive_enable_second),
   .phase_a_high_cmd_n(phase_a_high_cmd_n), .phase_a_low_cmd(phase_a_low_cmd),
   .phase_a_switch_node(phase_a_switch_node), .overcurrent_detect(overcurrent_detect),
   .spi_cs_n(spi_cs_n), .spi_so_oe(spi_so_oe), .interrupt_out(interrupt_out),
   .phase_a_level_status(phase_a_level_status), .phase_a_high_gate(phase_a_high_gate),
   .phase_a_low_gate(phase_a_low_gate));
`default_nettype wire

// ### dv/gpd_host.sv
// Controller model that runs serial frames on the pre-driver's port.
`timescale 1ns/1ps
`default_nettype none
module gpd_host (
   // Core clock and serial answer.
   input wire logic clk,
   input wire logic spi_so_out,
   input wire logic spi_so_oe,
   // Serial request lines.
   output logic spi_cs_n,
   output logic spi_sclk,
   output logic spi_si
);
   initial begin
      spi_cs_n = 1'b1;
      spi_sclk = 1'b1;
      spi_si = 1'b0;
   end
   // Each serial clock phase lasts four core cycles.
   task automatic half();
      repeat (4) @(posedge clk);
      #1;
   endtask
   task automatic xfer(input logic [15:0] w, input int nbits, output logic [15:0] r);
      r = 16'h0000;
      spi_cs_n = 1'b0;
      half();
      for (int i = 0; i < nbits; i++) begin
         spi_si = w[15 - i];
         half();
         spi_sclk = 1'b0;
         half();
         // SO changes on the first core cycle of the low phase at this rate, so it is taken before the rise.
         r = {r[14:0], spi_so_out};
         spi_sclk = 1'b1;
      end
      half();
      spi_cs_n = 1'b1;
      spi_si = ~spi_si;
      half();
   endtask
endmodule // gpd_host
`default_nettype wire

// ### dv/tb_top.sv
// Self-checking testbench for the gate pre-driver interface.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic clk, rstn, en1, en2, ce;
   logic [2:0] hi_n, lo, node, flt;
   logic [15:0] r;
   wire [2:0] hg, lg, lvl;
   wire so, so_oe, irq, cs_n, sclk, si;
   int mismatches, n_checks, cyc;
   gpd_predriver_if i_dut (.clk(clk), .rstn(rstn), .ce(ce),
      .drive_enable_first(en1), .drive_enable_second(en2),
      .phase_a_high_cmd_n(hi_n[0]), .phase_b_high_cmd_n(hi_n[1]),
      .phase_c_high_cmd_n(hi_n[2]), .phase_a_low_cmd(lo[0]), .phase_b_low_cmd(lo[1]),
      .phase_c_low_cmd(lo[2]), .phase_a_switch_node(node[0]), .phase_b_switch_node(node[1]),
      .phase_c_switch_node(node[2]), .overcurrent_detect(flt[0]), .desat_detect(flt[1]),
      .phase_fault_detect(flt[2]), .spi_cs_n(cs_n), .spi_sclk(sclk), .spi_si(si),
      .spi_so_out(so), .spi_so_oe(so_oe), .phase_a_high_gate(hg[0]),
      .phase_b_high_gate(hg[1]), .phase_c_high_gate(hg[2]), .phase_a_low_gate(lg[0]),
      .phase_b_low_gate(lg[1]), .phase_c_low_gate(lg[2]), .phase_a_level_status(lvl[0]),
      .phase_b_level_status(lvl[1]), .phase_c_level_status(lvl[2]), .interrupt_out(irq));
   gpd_host i_host (.clk(clk), .spi_so_out(so), .spi_so_oe(so_oe), .spi_cs_n(cs_n),
      .spi_sclk(sclk), .spi_si(si));
   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end
   always @(posedge clk) begin
      cyc++;
      if (cyc == 20000) begin
         mismatches++;
         tally_and_finish();
      end
   end
   task automatic step(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic chk(input string s, input logic [15:0] e, input logic [15:0] g);
      n_checks++;
      if (g !== e) begin
         mismatches++;
         $display("[FAIL] %s expected %h seen %h", s, e, g);
      end
   endtask
   task automatic frame(input logic [15:0] w);
      i_host.xfer(w, 16, r);
      step(8);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic t_idle();
      chk("so_oe", 0, so_oe);
      frame(16'h0000);
      chk("reply", {4'h0, node, 8'h14, 1'b0}, r);
      node = 3'h2;
      step(8);
      chk("level", 3'h2, lvl);
      $display("t_idle done");
   endtask
   task automatic t_gates();
      en1 = 1'b1;
      en2 = 1'b1;
      for (int p = 0; p < 3; p++) begin
         hi_n[p] = 1'b0;
         step(30);
         chk("high", 16'(1 << p), {lg, hg});
         hi_n[p] = 1'b1;
         lo[p] = 1'b1;
         step(30);
         chk("low", 16'(8 << p), {lg, hg});
         hi_n[p] = 1'b0;
         step(30);
         chk("both", 0, {lg, hg});
         hi_n[p] = 1'b1;
         lo[p] = 1'b0;
      end
      $display("t_gates done");
   endtask
   task automatic t_en();
      hi_n[1] = 1'b0;
      for (int k = 0; k < 2; k++) begin
         step(30);
         chk("on", 16'h0002, {lg, hg});
         {en1, en2} = k ? 2'b10 : 2'b01;
         step(8);
         chk("en off", 0, {lg, hg});
         {en1, en2} = 2'b11;
      end
      hi_n[1] = 1'b1;
      $display("t_en done");
   endtask
   task automatic t_ce();
      ce = 1'b0;
      hi_n[0] = 1'b0;
      step(20);
      chk("frozen", 0, hg[0]);
      ce = 1'b1;
      step(10);
      chk("thawed", 1, hg[0]);
      hi_n[0] = 1'b1;
      step(30);
      $display("t_ce done");
   endtask
   task automatic t_dead();
      logic [7:0] ask [3] = '{8'h03, 8'h00, 8'hFF};
      logic [7:0] want [3] = '{8'h03, 8'h01, 8'hF0};
      int n;
      for (int k = 0; k < 3; k++) begin
         frame({8'h20, ask[k]});
         frame(16'h0000);
         chk("dt field", want[k], r[8:1]);
         hi_n[0] = 1'b0;
         step(260);
         hi_n[0] = 1'b1;
         lo[0] = 1'b1;
         n = 0;
         while (hg[0] !== 1'b0 && n < 20) begin
            step(1);
            n++;
         end
         n = 0;
         while (lg[0] !== 1'b1 && n < 300) begin
            step(1);
            n++;
         end
         chk("dt gap", want[k], 16'(n));
         lo[0] = 1'b0;
         step(260);
      end
      $display("t_dead done");
   endtask
   task automatic t_fault();
      for (int i = 0; i < 3; i++) begin
         flt[i] = 1'b1;
         step(10);
         chk("irq", 1, irq);
         flt[i] = 1'b0;
         frame(16'h0000);
         chk("faults", {1'b1, 3'b001 << i}, r[15:12]);
         frame({13'h0800, 3'b111 ^ (3'b001 << i)});
         chk("irq held", 1, irq);
         frame({13'h0800, 3'b001 << i});
         chk("irq clr", 0, irq);
      end
      $display("t_fault done");
   endtask
   task automatic t_err();
      i_host.xfer(16'h2005, 15, r);
      step(8);
      frame(16'h0000);
      chk("err", 1, r[0]);
      chk("dt kept", 8'hF0, r[8:1]);
      frame(16'h0000);
      chk("err clr", 0, r[0]);
      $display("t_err done");
   endtask
   task automatic t_rst();
      hi_n[2] = 1'b0;
      flt[0] = 1'b1;
      step(260);
      chk("pre", 16'h0044, {irq, lg, hg});
      rstn = 1'b0;
      #1 chk("async", 0, {irq, so_oe, lg, hg});
      flt[0] = 1'b0;
      hi_n[2] = 1'b1;
      step(2);
      rstn = 1'b1;
      step(4);
      frame(16'h0000);
      chk("dt back", 8'h14, r[8:1]);
      $display("t_rst done");
   endtask
   initial begin
      rstn = 1'b0;
      ce = 1'b1;
      en1 = 1'b0;
      en2 = 1'b0;
      hi_n = 3'h7;
      lo = 3'h0;
      node = 3'h5;
      flt = 3'h0;
      step(5);
      chk("reset out", 0, {irq, so_oe, lg, hg});
      rstn = 1'b1;
      step(4);
      t_idle();
      t_gates();
      t_en();
      t_ce();
      t_dead();
      t_fault();
      t_err();
      t_rst();
      tally_and_finish();
   end
endmodule // tb_top
`default_nettype wire
